/* src/ctbi_pkg.sv */
package ctbi_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned ASID_W = 16;
   localparam int unsigned VMID_W = 16;
   localparam int unsigned VA_W   = 64;

   // register byte offsets
   localparam logic [11:0] OFS_INV_ALL     = 12'h000;
   localparam logic [11:0] OFS_INV_SPACE   = 12'h004;
   localparam logic [11:0] OFS_INV_VA_LO   = 12'h008;
   localparam logic [11:0] OFS_INV_VA_HI   = 12'h00C;
   localparam logic [11:0] OFS_INV_VAA_LO  = 12'h010;
   localparam logic [11:0] OFS_INV_VAA_HI  = 12'h014;
   localparam logic [11:0] OFS_BANK_CFG    = 12'h020;
   localparam logic [11:0] OFS_STATUS      = 12'h024;

   // bank configuration fields
   localparam int unsigned CFG_HYP_BIT     = 0;
   localparam int unsigned CFG_MON_BIT     = 1;
   localparam int unsigned CFG_SEC_BIT     = 2;
   localparam int unsigned CFG_WIDE_BIT    = 3;
   localparam int unsigned CFG_AS16_BIT    = 4;
   localparam int unsigned CFG_SCH64_BIT   = 5;
   localparam int unsigned CFG_GRAN_LSB    = 6;
   localparam int unsigned CFG_V2_BIT      = 8;
   localparam int unsigned CFG_VMID_LSB    = 16;
   localparam logic [31:0] CFG_RST         = 32'h0000_0100;
   localparam logic [31:0] CFG_WMASK       = 32'hFFFF_01FF;

   // status fields
   localparam int unsigned STAT_BUSY_BIT   = 0;
   localparam int unsigned STAT_CNT_LSB    = 16;

   localparam logic [1:0]  GRAN_4K         = 2'h0;
   localparam logic [1:0]  GRAN_16K        = 2'h1;
   localparam logic [1:0]  GRAN_64K        = 2'h2;

   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   localparam logic [2:0]  HSIZE_WORD      = 3'h2;
   localparam logic        HRESP_OKAY      = 1'h0;

   typedef enum logic [1:0] {
      OP_ALL   = 2'b00,
      OP_SPACE = 2'b01,
      OP_VA    = 2'b10,
      OP_VAA   = 2'b11
   } ctbi_op_t;

   typedef struct packed {
      ctbi_op_t            op;
      logic [ASID_W-1:0]   asid;
      logic [VA_W-1:0]     va;
      logic [VMID_W-1:0]   vmid;
      logic                match_vmid;
      logic                match_asid;
      logic                match_va;
      logic                incl_global;
      logic                scope_hyp;
      logic                scope_mon;
      logic                scope_secure;
   } ctbi_req_t;

endpackage

/* src/ctbi_inval_front.sv */
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps

// How it works
// - invalidate-all targets the bank class: hypervisor, own VMID, or secure any id
// - any write to the invalidate-all register triggers it; data ignored
// - ordinary non-secure bank: invalidate-all matches the bank VMID
// - hypervisor bank: invalidate-all hits hypervisor entries, VMID not matched
// - monitor bank: invalidate-all scoped to monitor entries
// - every request scoped to bank security state; secure banks ignore VMID
// - over-invalidation allowed, locked entries never removed
// - by-identifier: matching id, non-global only, plus VMID on ordinary banks
// - by-identifier id in low bits, 16 wide in version 2 with 64-bit scheme and 16-bit setting, 8 otherwise
// - 32-bit scheme forces id bits 15:8 to zero
// - by-address matches address, id and VMID; globals skip id check
// - hypervisor bank by-address ignores VMID and identifier
// - wide format: lone low write zero-extends, upper half only via pair
// - narrow format: upper half of any access ignored
// - wide by-address: id 63:48, address 55:12 in 43:0
// - 64KB granule drops address 15:12, 16KB drops 13:12
// - address sign-extended from bit 55 only
// - narrow by-address: address 31:12, id 7:0
// - any-id by-address: any id, globals included, VMID on ordinary banks
module ctbi_inval_front
   import ctbi_pkg::*;
(
   input  logic               hclk,             // bus clock
   input  logic               hresetn,          // async reset, active low
   input  logic               hsel,             // slave select
   input  logic [31:0]        haddr,            // byte address
   input  logic [1:0]         htrans,           // transfer type
   input  logic               hwrite,           // write when high
   input  logic [2:0]         hsize,            // transfer size
   input  logic               hready,           // bus ready
   input  logic [31:0]        hwdata,           // write data
   output logic [31:0]        hrdata,           // read data
   output logic               hreadyout,        // slave ready
   output logic               hresp,            // always okay
   output logic               inv_req_valid,    // request pending
   input  logic               inv_req_ready,    // storage takes request
   output logic [1:0]         inv_op,           // operation code
   output logic [ASID_W-1:0]  inv_asid,         // identifier to match
   output logic [VA_W-1:0]    inv_va,           // extended address
   output logic [VMID_W-1:0]  inv_vmid,         // bank vmid
   output logic               inv_match_vmid,   // compare vmid
   output logic               inv_match_asid,   // compare id on non-global
   output logic               inv_match_va,     // compare address
   output logic               inv_incl_global,  // global entries in scope
   output logic               inv_scope_hyp,    // hypervisor entries only
   output logic               inv_scope_mon,    // monitor entries only
   output logic               inv_scope_secure, // security state of entries
   output logic               inv_keep_locked   // locked entries are spared
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic is_trigger(input logic [ADDR_W-1:0] a);
      is_trigger = (a == OFS_INV_ALL) || (a == OFS_INV_SPACE) ||
                   (a == OFS_INV_VA_LO) || (a == OFS_INV_VAA_LO);
   endfunction

   function automatic ctbi_req_t build_req(input ctbi_op_t    op,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi,
                                           input logic [31:0] cfg);
      ctbi_req_t   r;
      logic        hyp;
      logic        mon;
      logic        sec;
      logic [1:0]  gran;
      logic [43:0] a;
      r    = '0;
      hyp  = cfg[CFG_HYP_BIT];
      mon  = cfg[CFG_MON_BIT];
      sec  = cfg[CFG_SEC_BIT];
      gran = cfg[CFG_GRAN_LSB +: 2];
      a    = '0;
      r.op = op;
      unique case (op)
         OP_ALL:   r.asid = '0;
         OP_SPACE: r.asid = lo[15:0];
         OP_VA:    r.asid = cfg[CFG_WIDE_BIT] ? hi[31:16] : {8'h00, lo[7:0]};
         OP_VAA:   r.asid = '0;
      endcase
      // narrow identifiers: version 1, 32-bit scheme, 8-bit setting
      if (!cfg[CFG_V2_BIT] || !cfg[CFG_SCH64_BIT] || !cfg[CFG_AS16_BIT])
      begin
         r.asid[15:8] = 8'h00;
      end
      if (hyp || mon)
      begin
         r.asid = '0;
      end
      if (op == OP_VA || op == OP_VAA)
      begin
         if (cfg[CFG_WIDE_BIT])
         begin
            a = {hi[11:0], lo};
         end
         else
         begin
            a = {24'h00_0000, lo[31:12]};
         end
         if (gran == GRAN_64K)
         begin
            a[3:0] = 4'h0;
         end
         else if (gran == GRAN_16K)
         begin
            a[1:0] = 2'h0;
         end
      end
      r.va           = {{8{a[43]}}, a, 12'h000};
      r.vmid         = cfg[CFG_VMID_LSB +: VMID_W];
      r.scope_hyp    = hyp;
      r.scope_mon    = mon;
      r.scope_secure = sec;
      r.match_vmid   = !sec && !hyp && !mon;
      r.match_asid   = (op == OP_SPACE) || (op == OP_VA && !hyp && !mon);
      r.match_va     = (op == OP_VA) || (op == OP_VAA);
      r.incl_global  = (op != OP_SPACE);
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus slave state

   logic                dp_r;
   logic                dp_write_r;
   logic                dp_word_r;
   logic [ADDR_W-1:0]   dp_addr_r;
   logic                hreadyout_r;
   logic [31:0]         hrdata_r;
   logic [31:0]         cfg_r;
   logic [31:0]         stage_r;
   logic                stage_ok_r;
   logic                stage_vaa_r;
   logic                req_valid_r;
   ctbi_req_t           req_r;
   logic [15:0]         issued_cnt_r;

   logic                addr_ok;
   logic                commit;
   logic                wr_commit;
   logic                trig_commit;
   logic                req_busy_nxt;
   ctbi_op_t            op_sel;
   logic [31:0]         upper;

   assign addr_ok      = hsel && htrans[1] && hready;
   assign commit       = dp_r && hreadyout_r;
   assign wr_commit    = commit && dp_write_r;
   // invalidate-all takes any width, argument registers need whole words
   assign trig_commit  = wr_commit && is_trigger(dp_addr_r) &&
                         (dp_word_r || dp_addr_r == OFS_INV_ALL);
   assign req_busy_nxt = (req_valid_r && !inv_req_ready) || trig_commit;

   always_comb
   begin
      unique case (dp_addr_r)
         OFS_INV_SPACE:  op_sel = OP_SPACE;
         OFS_INV_VA_LO:  op_sel = OP_VA;
         OFS_INV_VAA_LO: op_sel = OP_VAA;
         default:        op_sel = OP_ALL;
      endcase
   end

   // upper half only counts after a matching high write in wide format
   always_comb
   begin
      upper = 32'h0000_0000;
      if (cfg_r[CFG_WIDE_BIT] && stage_ok_r &&
          (stage_vaa_r == (op_sel == OP_VAA)))
      begin
         upper = stage_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address and data phase, wait states only when a request is still pending

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_r        <= 1'b0;
         dp_write_r  <= 1'b0;
         dp_word_r   <= 1'b0;
         dp_addr_r   <= '0;
         hreadyout_r <= 1'b1;
      end
      else if (addr_ok)
      begin
         dp_r        <= 1'b1;
         dp_write_r  <= hwrite;
         dp_word_r   <= (hsize == HSIZE_WORD);
         dp_addr_r   <= haddr[ADDR_W-1:0];
         hreadyout_r <= !(hwrite && is_trigger(haddr[ADDR_W-1:0]) && req_busy_nxt);
      end
      else if (commit)
      begin
         dp_r        <= 1'b0;
         hreadyout_r <= 1'b1;
      end
      else if (dp_r)
      begin
         hreadyout_r <= !req_busy_nxt;
      end
   end

   // operation registers read as zero, as do unmapped offsets
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_r <= 32'h0000_0000;
      end
      else if (addr_ok && !hwrite)
      begin
         unique case (haddr[ADDR_W-1:0])
            OFS_BANK_CFG: hrdata_r <= cfg_r;
            OFS_STATUS:   hrdata_r <= {issued_cnt_r, 15'h0000, req_valid_r};
            default:      hrdata_r <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_r <= CFG_RST;
      end
      else if (wr_commit && dp_word_r && dp_addr_r == OFS_BANK_CFG)
      begin
         cfg_r <= hwdata & CFG_WMASK;
      end
   end

   // high half is held until the next trigger write, which uses it only if it completes the pair
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stage_r     <= 32'h0000_0000;
         stage_ok_r  <= 1'b0;
         stage_vaa_r <= 1'b0;
      end
      else if (wr_commit && dp_word_r &&
               (dp_addr_r == OFS_INV_VA_HI || dp_addr_r == OFS_INV_VAA_HI))
      begin
         stage_r     <= hwdata;
         stage_ok_r  <= 1'b1;
         stage_vaa_r <= (dp_addr_r == OFS_INV_VAA_HI);
      end
      else if (trig_commit)
      begin
         stage_ok_r  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request toward storage

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         req_valid_r <= 1'b0;
         req_r       <= '0;
      end
      else if (trig_commit)
      begin
         req_valid_r <= 1'b1;
         req_r       <= build_req(op_sel, hwdata, upper, cfg_r);
      end
      else if (inv_req_ready)
      begin
         req_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         issued_cnt_r <= 16'h0000;
      end
      else if (req_valid_r && inv_req_ready)
      begin
         issued_cnt_r <= issued_cnt_r + 16'h0001;
      end
   end

   assign hrdata           = hrdata_r;
   assign hreadyout        = hreadyout_r;
   assign hresp            = HRESP_OKAY;
   assign inv_req_valid    = req_valid_r;
   assign inv_op           = req_r.op;
   assign inv_asid         = req_r.asid;
   assign inv_va           = req_r.va;
   assign inv_vmid         = req_r.vmid;
   assign inv_match_vmid   = req_r.match_vmid;
   assign inv_match_asid   = req_r.match_asid;
   assign inv_match_va     = req_r.match_va;
   assign inv_incl_global  = req_r.incl_global;
   assign inv_scope_hyp    = req_r.scope_hyp;
   assign inv_scope_mon    = req_r.scope_mon;
   assign inv_scope_secure = req_r.scope_secure;
   // storage may over-invalidate but must spare locked entries
   assign inv_keep_locked  = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_all_any_write: assert property (
      (wr_commit && dp_addr_r == OFS_INV_ALL) |=> (inv_req_valid && inv_op == OP_ALL))
      else $error("invalidate-all write gave no request");

   chk_one_request: assert property (
      (inv_req_valid && !inv_req_ready) |=> (inv_req_valid && $stable(inv_va) &&
                                             $stable(inv_op) && $stable(inv_asid)))
      else $error("pending request changed or dropped");

   chk_hyp_no_vmid: assert property (
      (inv_req_valid && inv_scope_hyp) |-> (!inv_match_vmid && !inv_match_asid))
      else $error("hypervisor request matches vmid or id");

   chk_secure_scope: assert property (
      inv_req_valid |-> (inv_match_vmid == (!inv_scope_secure && !inv_scope_hyp &&
                                            !inv_scope_mon)))
      else $error("vmid match does not follow bank class");

   chk_space_nonglobal: assert property (
      (inv_req_valid && inv_op == OP_SPACE) |-> (inv_match_asid && !inv_incl_global &&
                                                 !inv_match_va))
      else $error("by-identifier scope wrong");

   chk_space_width: assert property (
      (trig_commit && dp_addr_r == OFS_INV_SPACE && !cfg_r[CFG_V2_BIT])
      |=> inv_asid[15:8] == 8'h00)
      else $error("version 1 identifier wider than 8 bits");

   chk_narrow_layout: assert property (
      (trig_commit && dp_addr_r == OFS_INV_VA_LO && !cfg_r[CFG_WIDE_BIT] &&
       !cfg_r[CFG_HYP_BIT] && !cfg_r[CFG_MON_BIT])
      |=> (inv_va[63:32] == 32'h0 && inv_va[31:12] == $past(hwdata[31:12]) &&
           inv_asid[7:0] == $past(hwdata[7:0])))
      else $error("narrow by-address fields misplaced");

   chk_granule_mask: assert property (
      (inv_req_valid && inv_match_va && $past(cfg_r[CFG_GRAN_LSB +: 2]) == GRAN_64K &&
       $rose(inv_req_valid)) |-> inv_va[15:12] == 4'h0)
      else $error("64KB granule address bits kept");

   chk_sign_ext: assert property (
      inv_req_valid |-> (inv_va[63:56] == {8{inv_va[55]}} && inv_va[11:0] == 12'h000))
      else $error("address not extended from bit 55");

   chk_any_id: assert property (
      (inv_req_valid && inv_op == OP_VAA) |-> (inv_incl_global && !inv_match_asid &&
                                               inv_match_va))
      else $error("any-id request checks identifier");

   cov_all:    cover property (trig_commit && dp_addr_r == OFS_INV_ALL);
   cov_stall:  cover property (dp_r && !hreadyout_r ##1 hreadyout_r);
   cov_pair:   cover property (stage_ok_r && trig_commit && cfg_r[CFG_WIDE_BIT]);
   cov_back:   cover property (inv_req_valid && inv_req_ready && trig_commit);

endmodule

/* bench/ctbi_tlb_model.sv */
`timescale 1ns/1ps

module ctbi_tlb_model
   import ctbi_pkg::*;
(
   input  logic        hclk,        // clock
   input  logic        hresetn,     // async reset, active low
   input  logic        slow,        // accept one cycle in three
   input  logic        stall,       // hold off all acceptance
   input  logic        valid,       // request pending
   input  logic        keep_locked, // locked entries to be spared
   input  ctbi_req_t   req,         // request fields
   output logic        ready,       // request taken at this edge
   output ctbi_req_t   got_r,       // last request taken
   output logic [15:0] cnt_r,       // requests taken
   output logic        lk_err_r     // request would hit locked entries
);

   logic [1:0] ph_r;

   ////////////////////////////////////////////////////////////////////////////////
   // slow mode stands in for storage busy with lookups
   assign ready = !stall && (!slow || ph_r == 2'h0);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ph_r <= 2'h0;
      else
         ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         got_r <= '0;
         cnt_r <= 16'h0;
      end
      else if (valid && ready)
      begin
         got_r <= req;
         cnt_r <= cnt_r + 16'h1;
      end
   end

   // storage may over-invalidate, but a locked line must survive
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         lk_err_r <= 1'b0;
      else if (valid && ready && !keep_locked)
         lk_err_r <= 1'b1;
   end

endmodule

/* bench/test_ctx_bank_tlb_invalidate_ops.sv */
`timescale 1ns/1ps

`define CMP(g, e) \
   begin \
      compares++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("mismatch at %0t ns: got %0h exp %0h", $time, (g), (e)); \
      end \
   end

module test_ctx_bank_tlb_invalidate_ops
   import ctbi_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow, stall, lk_err;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, inv_op;
   logic [2:0]  hsize;
   logic        inv_req_valid, inv_req_ready, inv_keep_locked;
   logic        inv_match_vmid, inv_match_asid, inv_match_va, inv_incl_global;
   logic        inv_scope_hyp, inv_scope_mon, inv_scope_secure;
   logic [15:0] inv_asid, inv_vmid, cnt, seen, vm;
   logic [63:0] inv_va;
   ctbi_req_t   req, got;
   int          miscompares, compares;
   logic [31:0] acfg [4] = '{32'h1234_0138, 32'h1234_0128, 32'h1234_0038, 32'h1234_0118};
   logic [15:0] aexp [4] = '{16'hABCD, 16'h00CD, 16'h00CD, 16'h00CD};
   logic [63:0] vexp [3] = '{64'hFF80_0876_5432_F000, 64'hFF80_0876_5432_C000,
                             64'hFF80_0876_5432_0000};

   assign req = '{ctbi_op_t'(inv_op), inv_asid, inv_va, inv_vmid, inv_match_vmid,
                  inv_match_asid, inv_match_va, inv_incl_global, inv_scope_hyp,
                  inv_scope_mon, inv_scope_secure};

   ctbi_inval_front dut_u (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready (hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
      .inv_req_valid, .inv_req_ready, .inv_op, .inv_asid, .inv_va, .inv_vmid,
      .inv_match_vmid, .inv_match_asid, .inv_match_va, .inv_incl_global,
      .inv_scope_hyp, .inv_scope_mon, .inv_scope_secure, .inv_keep_locked
   );

   ctbi_tlb_model tlb_u (
      .hclk, .hresetn, .slow, .stall, .valid (inv_req_valid),
      .keep_locked (inv_keep_locked), .req, .ready (inv_req_ready),
      .got_r (got), .cnt_r (cnt), .lk_err_r (lk_err)
   );

   always #50 hclk = ~hclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // a wait that never sees ready ends the run
   task automatic rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 400);
      if (hreadyout !== 1'b1)
      begin
         miscompares++;
         tally_and_finish();
      end
   endtask

   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr  <= {20'h0, a};
      hwrite <= w;
      hsize  <= HSIZE_WORD;
      rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      rd = hrdata;
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      `CMP(rd, e)
   endtask

   task automatic cf(input logic [31:0] d);
      bus(OFS_BANK_CFG, 1'b1, d);
      vm = d[31:16];
   endtask

   // flags: vmid, id, address, global, hyp, mon, secure
   task automatic ex(input ctbi_op_t op, input logic [15:0] id, input logic [63:0] va,
                     input logic [6:0] fl);
      int        n;
      ctbi_req_t e, g;
      n = 0;
      while (cnt === seen && n < 400)
      begin
         @(posedge hclk);
         n++;
      end
      #1;
      if (cnt === seen)
      begin
         miscompares++;
         tally_and_finish();
      end
      seen = cnt;
      e = '{op, id, va, vm, fl[6], fl[5], fl[4], fl[3], fl[2], fl[1], fl[0]};
      g = got;
      if (op inside {OP_ALL, OP_SPACE})
      begin
         e.va = '0;
         g.va = '0;
      end
      `CMP(g, e)
      `CMP(inv_keep_locked, 1'b1)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {hclk, hresetn, hsel, hwrite, slow, stall} = '0;
      {haddr, hwdata, htrans, hsize, seen, vm} = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      bus(12'h080, 1'b1, 32'hFFFF_FFFF);
      rc(OFS_STATUS, 32'h0);
      rc(OFS_INV_ALL, 32'h0);
      $display("test reset done");

      cf(32'h1234_0138);
      bus(OFS_INV_ALL, 1'b1, 32'hFFFF_FFFF);
      ex(OP_ALL, 16'h0, 64'h0, 7'b1001000);
      for (int i = 0; i < 4; i++)
      begin
         cf(acfg[i]);
         bus(OFS_INV_SPACE, 1'b1, 32'hFFFF_ABCD);
         ex(OP_SPACE, aexp[i], 64'h0, 7'b1100000);
      end
      $display("test ordinary bank done");

      slow <= 1'b1;
      cf(32'h1234_0138);
      bus(OFS_INV_VA_LO, 1'b1, 32'h8765_432F);
      ex(OP_VA, 16'h0, 64'h0000_0876_5432_F000, 7'b1111000);
      for (int g = 0; g < 3; g++)
      begin
         cf({16'h1234, 8'h01, g[1:0], 6'h38});
         bus(OFS_INV_VA_HI, 1'b1, 32'h1234_0800);
         bus(OFS_INV_VA_LO, 1'b1, 32'h8765_432F);
         ex(OP_VA, 16'h1234, vexp[g], 7'b1111000);
      end
      cf(32'h1234_0138);
      bus(OFS_INV_VAA_HI, 1'b1, 32'hFFFF_0001);
      bus(OFS_INV_VAA_LO, 1'b1, 32'h0000_0002);
      ex(OP_VAA, 16'h0, 64'h0000_1000_0000_2000, 7'b1011000);
      cf(32'h1234_0100);
      bus(OFS_INV_VA_HI, 1'b1, 32'hFFFF_FFFF);
      bus(OFS_INV_VA_LO, 1'b1, 32'hFEDC_B5A7);
      ex(OP_VA, 16'h00A7, 64'h0000_0000_FEDC_B000, 7'b1111000);
      slow <= 1'b0;
      $display("test address formats done");

      cf(32'h55AA_0101);
      bus(OFS_INV_ALL, 1'b1, 32'h0);
      ex(OP_ALL, 16'h0, 64'h0, 7'b0001100);
      bus(OFS_INV_VA_LO, 1'b1, 32'h0001_3000);
      ex(OP_VA, 16'h0, 64'h0000_0000_0001_3000, 7'b0011100);
      cf(32'h55AA_0102);
      bus(OFS_INV_ALL, 1'b1, 32'h0);
      ex(OP_ALL, 16'h0, 64'h0, 7'b0001010);
      cf(32'h55AA_0104);
      bus(OFS_INV_ALL, 1'b1, 32'h0);
      ex(OP_ALL, 16'h0, 64'h0, 7'b0001001);
      bus(OFS_INV_SPACE, 1'b1, 32'h0000_0042);
      ex(OP_SPACE, 16'h0042, 64'h0, 7'b0100001);
      $display("test bank classes done");

      // second trigger must stall on the bus until storage frees up
      cf(32'h1234_0138);
      stall <= 1'b1;
      fork
         begin
            bus(OFS_INV_ALL, 1'b1, 32'h0);
            bus(OFS_INV_SPACE, 1'b1, 32'h0000_0077);
         end
         begin
            repeat (30) @(posedge hclk);
            `CMP(inv_req_valid, 1'b1)
            `CMP(hreadyout, 1'b0)
            `CMP(hresp, HRESP_OKAY)
            `CMP(cnt, seen)
            stall <= 1'b0;
         end
      join
      seen = seen + 16'h1;
      ex(OP_SPACE, 16'h0077, 64'h0, 7'b1100000);
      rc(OFS_STATUS, {seen, 15'h0, 1'b0});
      `CMP(lk_err, 1'b0)
      $display("test back to back done");
      tally_and_finish();
   end

endmodule
